// ===== rtl/tomux_top.sv
`timescale 1ns/1ps

// How it works
// R01: two selector instances, each with its own select field, drive the two test pins independently.
// R02: the first pin follows the source picked by bits 4..0 of the register at index 0x2502.
// R03: the second pin follows the source picked by bits 4..0 of the register at index 0x2503.
// R04: both select fields live in battery-backed storage that no system reset touches.
// R05: on the first pin code 9 gives the watchdog refresh pulse and code A the processor clock.
// R06: on the first pin code D gives the accurate-supply flag and code E the usable-supply flag.
// R07: software is expected to write only listed codes to the first select field.
// R08: on the second pin code 0 gives the watchdog overflow indication.
// R09: on the second pin code 1 gives the one-second pulse and code 3 the rtc clock wave.
// R10: on the second pin code 2 gives the four-second pulse.
// R11: on the second pin codes 8 and 9 give spare bits 1 and 2 of the register at index 0x2704.
// R12: on the second pin code A gives the wake event, B the frame sync and C the front-end master clock.
// R13: on the second pin code E holds the pin at digital ground.
// R14: on the second pin codes 12..18 give interrupt lines 0..6 and code 1F the realtime monitor clock.
// R15: software is expected to write only listed codes to the second select field.
// R16: each pin is its selected source passed through one flop, and any reserved code drives it low.

module tomux_top
  import tomux_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // backup-domain init, clears the select fields
  input wire logic NV_INIT,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // first selector sources
  input wire logic WATCHDOG_REFRESH_PULSE,
  input wire logic PROCESSOR_CLOCK,
  input wire logic SUPPLY_ACCURATE_FLAG,
  input wire logic SUPPLY_USABLE_FLAG,
  input wire logic FRAME_SYNC,
  input wire logic COMPUTE_BUSY_IRQ,
  input wire logic COMPUTE_TRANSFER_IRQ,
  input wire logic REALTIME_MONITOR_OUT,
  // second selector sources
  input wire logic WATCHDOG_OVERFLOW,
  input wire logic ONE_SECOND_PULSE,
  input wire logic FOUR_SECOND_PULSE,
  input wire logic RTC_CLOCK_WAVE,
  input wire logic WAKE_EVENT,
  input wire logic FRONTEND_MASTER_CLOCK,
  input wire logic [6:0] IRQ_LINES,
  input wire logic REALTIME_MONITOR_CLOCK,
  // test pins
  output logic TEST_OUT_PIN,
  output logic TEST_OUT2_PIN
);

  tomux_state_t state_q;
  tomux_state_t state_d;
  tomux_wb_req_t req;
  tomux_src_t src;

  logic [31:0] src_vec [2];
  logic [7:0] nv_value [2];
  logic [13:0] nv_index [2];
  logic nv_wr [2];
  logic sel_out [2];
  logic [13:0] word_idx;
  logic wr_commit;
  logic [31:0] rd_value;

  assign req.cyc = WB_CYC_I;
  assign req.stb = WB_STB_I;
  assign req.we = WB_WE_I;
  assign req.adr = WB_ADR_I;
  assign req.sel = WB_SEL_I;
  assign req.dat = WB_DAT_I;

  assign src.watchdog_refresh_pulse = WATCHDOG_REFRESH_PULSE;
  assign src.processor_clock = PROCESSOR_CLOCK;
  assign src.supply_accurate_flag = SUPPLY_ACCURATE_FLAG;
  assign src.supply_usable_flag = SUPPLY_USABLE_FLAG;
  assign src.frame_sync = FRAME_SYNC;
  assign src.compute_busy_irq = COMPUTE_BUSY_IRQ;
  assign src.compute_transfer_irq = COMPUTE_TRANSFER_IRQ;
  assign src.realtime_monitor_out = REALTIME_MONITOR_OUT;
  assign src.watchdog_overflow = WATCHDOG_OVERFLOW;
  assign src.one_second_pulse = ONE_SECOND_PULSE;
  assign src.four_second_pulse = FOUR_SECOND_PULSE;
  assign src.rtc_clock_wave = RTC_CLOCK_WAVE;
  assign src.wake_event = WAKE_EVENT;
  assign src.frontend_master_clock = FRONTEND_MASTER_CLOCK;
  assign src.irq_lines = IRQ_LINES;
  assign src.realtime_monitor_clock = REALTIME_MONITOR_CLOCK;

  assign word_idx = req.adr[15:2];

  // the write lands on the edge where the master sees ack high
  assign wr_commit = (state_q.bus == BUS_ACK) && req.cyc && req.stb && req.we && req.sel[0];

  assign nv_index[0] = `TOMUX_IDX_SEL1; // R02
  assign nv_index[1] = `TOMUX_IDX_SEL2; // R03

  // source vector of the first pin, unlisted codes stay zero
  always_comb begin
    src_vec[0] = 32'h0000_0000; // R16 R07
    src_vec[0][`TOMUX_C1_WDREF] = src.watchdog_refresh_pulse; // R05
    src_vec[0][`TOMUX_C1_CPUCLK] = src.processor_clock; // R05
    src_vec[0][`TOMUX_C1_SUPACC] = src.supply_accurate_flag; // R06
    src_vec[0][`TOMUX_C1_SUPUSE] = src.supply_usable_flag; // R06
    src_vec[0][`TOMUX_C1_FSYNC] = src.frame_sync;
    src_vec[0][`TOMUX_C1_BUSY] = src.compute_busy_irq;
    src_vec[0][`TOMUX_C1_XFER] = src.compute_transfer_irq;
    src_vec[0][`TOMUX_C1_RTMOUT] = src.realtime_monitor_out;
  end

  // source vector of the second pin; the ground code is just a zero
  always_comb begin
    src_vec[1] = 32'h0000_0000; // R16 R15 R13
    src_vec[1][`TOMUX_C2_WDOVF] = src.watchdog_overflow; // R08
    src_vec[1][`TOMUX_C2_P1S] = src.one_second_pulse; // R09
    src_vec[1][`TOMUX_C2_P4S] = src.four_second_pulse; // R10
    src_vec[1][`TOMUX_C2_RTCW] = src.rtc_clock_wave; // R09
    src_vec[1][`TOMUX_C2_SPARE1] = state_q.spare[`TOMUX_SPARE_BIT1]; // R11
    src_vec[1][`TOMUX_C2_SPARE2] = state_q.spare[`TOMUX_SPARE_BIT2]; // R11
    src_vec[1][`TOMUX_C2_WAKE] = src.wake_event; // R12
    src_vec[1][`TOMUX_C2_FSYNC] = src.frame_sync; // R12
    src_vec[1][`TOMUX_C2_MCLK] = src.frontend_master_clock; // R12
    src_vec[1][`TOMUX_C2_GND] = 1'b0; // R13
    for (int i = 0; i < `TOMUX_NUM_IRQ; i++) begin
      src_vec[1][`TOMUX_C2_IRQ_BASE + i] = src.irq_lines[i]; // R14
    end
    src_vec[1][`TOMUX_C2_RTMCLK] = src.realtime_monitor_clock; // R14
  end

  // one selector and one battery-backed select field per pin
  for (genvar k = 0; k < 2; k++) begin : g_chan
    assign nv_wr[k] = wr_commit && (word_idx == nv_index[k]);

    tomux_nvreg u_field (
      .clk(CLK_SYS),
      .clk_en(CLK_EN),
      .nv_init(NV_INIT), // R04
      .wr_en(nv_wr[k]),
      .wr_data(req.dat[7:0]),
      .value(nv_value[k])
    );

    tomux_sel u_sel (
      .sources(src_vec[k]),
      .code(nv_value[k][`TOMUX_SEL_MSB:`TOMUX_SEL_LSB]), // R01
      .chosen(sel_out[k])
    );
  end

  // read decode; unmapped words answer with zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (word_idx)
      `TOMUX_IDX_SEL1: begin
        rd_value[7:0] = nv_value[0];
      end
      `TOMUX_IDX_SEL2: begin
        rd_value[7:0] = nv_value[1];
      end
      `TOMUX_IDX_SPARE: begin
        rd_value[7:0] = state_q.spare;
      end
      `TOMUX_IDX_STATUS: begin
        rd_value[`TOMUX_STAT_OUT1] = state_q.out1;
        rd_value[`TOMUX_STAT_OUT2] = state_q.out2;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    // pins pass through one flop so the top outputs are registered;
    // costs one cycle of latency and samples the routed clocks at the system rate
    state_d.out1 = sel_out[0]; // R16 R01
    state_d.out2 = sel_out[1]; // R16 R01
    case (state_q.bus)
      BUS_IDLE: begin
        state_d.ack = 1'b0;
        if (req.cyc && req.stb) begin
          state_d.bus = BUS_ACK;
          state_d.ack = 1'b1;
          state_d.rdat = rd_value;
        end
      end
      BUS_ACK: begin
        state_d.bus = BUS_IDLE;
        state_d.ack = 1'b0;
        if (wr_commit && (word_idx == `TOMUX_IDX_SPARE)) begin
          state_d.spare = req.dat[7:0];
        end
      end
      default: begin
        state_d.bus = BUS_IDLE;
        state_d.ack = 1'b0;
      end
    endcase
  end

  // select fields are not part of this state, so the system reset leaves them alone
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_q.bus <= BUS_IDLE; // R04
      state_q.ack <= 1'b0;
      state_q.rdat <= `TOMUX_RDAT_RST;
      state_q.spare <= `TOMUX_SPARE_RST;
      state_q.out1 <= 1'b0;
      state_q.out2 <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
    end
  end

  assign WB_ACK_O = state_q.ack;
  assign WB_DAT_O = state_q.rdat;
  assign TEST_OUT_PIN = state_q.out1;
  assign TEST_OUT2_PIN = state_q.out2;

endmodule

// ===== include/tomux_consts.svh
`ifndef TOMUX_CONSTS_SVH
`define TOMUX_CONSTS_SVH

// register indices; byte address is four times the index
`define TOMUX_IDX_SEL1 14'h2502
`define TOMUX_IDX_SEL2 14'h2503
`define TOMUX_IDX_STATUS 14'h2505
`define TOMUX_IDX_SPARE 14'h2704

// field layout
`define TOMUX_SEL_MSB 4
`define TOMUX_SEL_LSB 0
`define TOMUX_SPARE_BIT1 1
`define TOMUX_SPARE_BIT2 2
`define TOMUX_STAT_OUT1 0
`define TOMUX_STAT_OUT2 1

// reset and init values
`define TOMUX_SPARE_RST 8'h00
`define TOMUX_NV_INIT_VAL 8'h00
`define TOMUX_RDAT_RST 32'h0000_0000

// first selector codes
`define TOMUX_C1_WDREF 5'h09
`define TOMUX_C1_CPUCLK 5'h0A
`define TOMUX_C1_SUPACC 5'h0D
`define TOMUX_C1_SUPUSE 5'h0E
`define TOMUX_C1_FSYNC 5'h1B
`define TOMUX_C1_BUSY 5'h1C
`define TOMUX_C1_XFER 5'h1D
`define TOMUX_C1_RTMOUT 5'h1F

// second selector codes
`define TOMUX_C2_WDOVF 5'h00
`define TOMUX_C2_P1S 5'h01
`define TOMUX_C2_P4S 5'h02
`define TOMUX_C2_RTCW 5'h03
`define TOMUX_C2_SPARE1 5'h08
`define TOMUX_C2_SPARE2 5'h09
`define TOMUX_C2_WAKE 5'h0A
`define TOMUX_C2_FSYNC 5'h0B
`define TOMUX_C2_MCLK 5'h0C
`define TOMUX_C2_GND 5'h0E
`define TOMUX_C2_IRQ_BASE 5'h12
`define TOMUX_C2_RTMCLK 5'h1F

`define TOMUX_NUM_IRQ 7

`endif

// ===== include/tomux_pkg.sv
`include "tomux_consts.svh"

package tomux_pkg;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } tomux_bus_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tomux_wb_req_t;

  typedef struct packed {
    logic watchdog_refresh_pulse;
    logic processor_clock;
    logic supply_accurate_flag;
    logic supply_usable_flag;
    logic frame_sync;
    logic compute_busy_irq;
    logic compute_transfer_irq;
    logic realtime_monitor_out;
    logic watchdog_overflow;
    logic one_second_pulse;
    logic four_second_pulse;
    logic rtc_clock_wave;
    logic wake_event;
    logic frontend_master_clock;
    logic [`TOMUX_NUM_IRQ-1:0] irq_lines;
    logic realtime_monitor_clock;
  } tomux_src_t;

  typedef struct packed {
    tomux_bus_t bus;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] spare;
    logic out1;
    logic out2;
  } tomux_state_t;

  typedef struct packed {
    logic [7:0] value;
  } tomux_nv_t;

endpackage

// ===== rtl/tomux_nvreg.sv
`timescale 1ns/1ps

module tomux_nvreg
  import tomux_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic clk_en,
  input wire logic nv_init,
  // write port
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // stored value
  output logic [7:0] value
);

  tomux_nv_t state_q;
  tomux_nv_t state_d;

  // battery-backed: no system reset here, only the backup-domain init
  always_comb begin
    state_d = state_q;
    if (nv_init) begin
      state_d.value = `TOMUX_NV_INIT_VAL;
    end else if (wr_en) begin
      state_d.value = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign value = state_q.value;

endmodule

// ===== rtl/tomux_sel.sv
`timescale 1ns/1ps

module tomux_sel
  import tomux_pkg::*;
(
  // candidate sources, one bit per code
  input wire logic [31:0] sources,
  // select field
  input wire logic [4:0] code,
  // chosen level
  output logic chosen
);

  // unlisted codes carry a zero in the source vector, so they read low
  assign chosen = sources[code];

endmodule

// ===== verification/tomux_props.sv
`timescale 1ns/1ps

module tomux_props (
  // clock and control
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic NV_INIT,
  // bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  // sources and pins
  input wire logic WATCHDOG_REFRESH_PULSE,
  input wire logic PROCESSOR_CLOCK,
  input wire logic SUPPLY_ACCURATE_FLAG,
  input wire logic FRAME_SYNC,
  input wire logic WATCHDOG_OVERFLOW,
  input wire logic RTC_CLOCK_WAVE,
  input wire logic [6:0] IRQ_LINES,
  input wire logic TEST_OUT_PIN,
  input wire logic TEST_OUT2_PIN
);
  // shadow select fields; no SYS_RST here, they live in the battery domain
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic wr;
  logic run;
  assign wr = CLK_EN && WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
  // a reset edge still clears the pins, so only count edges with reset low
  assign run = CLK_EN && !SYS_RST;
  always_ff @(posedge CLK_SYS) begin
    if (CLK_EN && NV_INIT) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      if (wr && WB_ADR_I[15:2] == 14'h2502) begin
        s1_q <= WB_DAT_I[4:0];
      end
      if (wr && WB_ADR_I[15:2] == 14'h2503) begin
        s2_q <= WB_DAT_I[4:0];
      end
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  a_pin1_refresh: assert property (run && s1_q == 5'h09 |=> TEST_OUT_PIN == $past(WATCHDOG_REFRESH_PULSE))
    else $error("pin 1 misses the refresh pulse");
  a_pins_indep: assert property (run && s1_q == 5'h0A && s2_q == 5'h03 |=>
    TEST_OUT_PIN == $past(PROCESSOR_CLOCK) && TEST_OUT2_PIN == $past(RTC_CLOCK_WAVE))
    else $error("pins not routed independently");
  a_pin1_supply: assert property (run && s1_q == 5'h0D |=> TEST_OUT_PIN == $past(SUPPLY_ACCURATE_FLAG))
    else $error("pin 1 misses the supply flag");
  a_pin2_overflow: assert property (run && s2_q == 5'h00 |=> TEST_OUT2_PIN == $past(WATCHDOG_OVERFLOW))
    else $error("pin 2 misses the overflow flag");
  a_pin2_frame: assert property (run && s2_q == 5'h0B |=> TEST_OUT2_PIN == $past(FRAME_SYNC))
    else $error("pin 2 misses the frame sync");
  a_pin2_irq: assert property (run && s2_q inside {[5'h12:5'h18]} |=>
    TEST_OUT2_PIN == $past(IRQ_LINES[s2_q - 5'h12]))
    else $error("pin 2 misses the interrupt line");
  a_pin2_ground: assert property (run && s2_q == 5'h0E |=> !TEST_OUT2_PIN)
    else $error("pin 2 not grounded");
  a_pin1_reserved: assert property (run && !(s1_q inside {5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h1B, 5'h1C, 5'h1D,
    5'h1F}) |=> !TEST_OUT_PIN)
    else $error("reserved code does not drive pin 1 low");
  a_ack_single: assert property ($rose(WB_ACK_O) |=> !WB_ACK_O)
    else $error("ack longer than one cycle");

  cover property (run && s1_q == 5'h09);
  cover property (run && s2_q == 5'h1F);
  cover property (WB_ACK_O && WB_WE_I);
endmodule

bind tomux_top tomux_props chk (.*);

// ===== verification/tomux_meter.sv
`timescale 1ns/1ps

module tomux_meter (
  // probes on the two test pins
  input wire logic clk,
  input wire logic probe1,
  input wire logic probe2,
  // rising edges seen so far
  output logic [15:0] rises1 = 16'h0000,
  output logic [15:0] rises2 = 16'h0000
);
  logic last1 = 1'b0;
  logic last2 = 1'b0;
  always @(posedge clk) begin
    if (probe1 && !last1) begin
      rises1 <= rises1 + 16'h0001;
    end
    if (probe2 && !last2) begin
      rises2 <= rises2 + 16'h0001;
    end
    last1 <= probe1;
    last2 <= probe2;
  end
endmodule

// ===== verification/tomux_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module tomux_tb_top;
  typedef struct packed {
    logic [4:0] c1;
    logic [4:0] i1;
    logic [4:0] c2;
    logic [4:0] i2;
  } tomux_row_t;
  logic CLK_SYS = 1'b0;
  logic SYS_RST = 1'b1;
  logic CLK_EN = 1'b1;
  logic NV_INIT = 1'b1;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [15:0] WB_ADR_I = 16'h0000;
  logic [3:0] WB_SEL_I = 4'h1;
  logic [31:0] WB_DAT_I = 32'h0000_0000;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic TEST_OUT_PIN;
  logic TEST_OUT2_PIN;
  // one bit per source; index 1F selects nothing
  logic [21:0] src = 22'h000000;
  logic [15:0] r1;
  logic [15:0] r2;
  logic [15:0] base;
  logic [31:0] rd;
  tomux_row_t r;
  int n_errors = 0;
  int checked = 0;
  tomux_row_t rows [17] = '{
    '{5'h09, 5'h00, 5'h00, 5'h08}, '{5'h0A, 5'h01, 5'h03, 5'h0B}, '{5'h0D, 5'h02, 5'h02, 5'h0A},
    '{5'h0E, 5'h03, 5'h01, 5'h09}, '{5'h1B, 5'h04, 5'h0A, 5'h0C}, '{5'h1C, 5'h05, 5'h0B, 5'h04},
    '{5'h1D, 5'h06, 5'h0C, 5'h0D}, '{5'h1F, 5'h07, 5'h0E, 5'h1F}, '{5'h00, 5'h1F, 5'h12, 5'h0F},
    '{5'h01, 5'h1F, 5'h13, 5'h10}, '{5'h03, 5'h1F, 5'h14, 5'h11}, '{5'h10, 5'h1F, 5'h15, 5'h12},
    '{5'h1E, 5'h1F, 5'h16, 5'h13}, '{5'h08, 5'h1F, 5'h17, 5'h14}, '{5'h0F, 5'h1F, 5'h18, 5'h15},
    '{5'h14, 5'h1F, 5'h1F, 5'h0E}, '{5'h12, 5'h1F, 5'h04, 5'h1F}};

  tomux_top DUT (.*, .WATCHDOG_REFRESH_PULSE(src[0]), .PROCESSOR_CLOCK(src[1]), .SUPPLY_ACCURATE_FLAG(src[2]),
    .SUPPLY_USABLE_FLAG(src[3]), .FRAME_SYNC(src[4]), .COMPUTE_BUSY_IRQ(src[5]), .COMPUTE_TRANSFER_IRQ(src[6]),
    .REALTIME_MONITOR_OUT(src[7]), .WATCHDOG_OVERFLOW(src[8]), .ONE_SECOND_PULSE(src[9]),
    .FOUR_SECOND_PULSE(src[10]), .RTC_CLOCK_WAVE(src[11]), .WAKE_EVENT(src[12]), .FRONTEND_MASTER_CLOCK(src[13]),
    .REALTIME_MONITOR_CLOCK(src[14]), .IRQ_LINES(src[21:15]));
  tomux_meter meter (.clk(CLK_SYS), .probe1(TEST_OUT_PIN), .probe2(TEST_OUT2_PIN), .rises1(r1), .rises2(r2));

  initial begin
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [13:0] idx, input logic [31:0] d);
    @(posedge CLK_SYS);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= {idx, 2'b00};
    WB_DAT_I <= d;
    // ack and read data are taken at the rising edge, before the slave moves them
    for (int i = 0; i < 20 && WB_ACK_O !== 1'b1; i++) begin
      @(posedge CLK_SYS);
    end
    if (WB_ACK_O !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask

  // pins follow at the same edge that first samples the new source
  task automatic apply(input logic [21:0] p, input logic e1, input logic e2);
    @(posedge CLK_SYS);
    src <= p;
    repeat (2) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK("pin1", e1, TEST_OUT_PIN)
    `CHK("pin2", e2, TEST_OUT2_PIN)
  endtask

  initial begin
    repeat (20) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    NV_INIT <= 1'b0;
    for (int k = 0; k < 17; k++) begin
      r = rows[k];
      wb(1'b1, 14'h2502, {27'h0, r.c1});
      wb(1'b1, 14'h2503, {27'h0, r.c2});
      apply((22'h1 << r.i1) | (22'h1 << r.i2), r.i1 != 5'h1F, r.i2 != 5'h1F);
      apply(~(22'h1 << r.i2), r.i1 != 5'h1F && r.i1 != r.i2, 1'b0);
    end
    $display("table done");
    wb(1'b1, 14'h2503, 32'h0000_0008);
    wb(1'b1, 14'h2704, 32'h0000_0002);
    apply(22'h0, 1'b0, 1'b1);
    wb(1'b1, 14'h2503, 32'h0000_0009);
    apply(22'h0, 1'b0, 1'b0);
    wb(1'b1, 14'h2704, 32'h0000_0004);
    apply(22'h0, 1'b0, 1'b1);
    wb(1'b1, 14'h0100, 32'h0000_00FF);
    wb(1'b0, 14'h0100, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("spare done");
    wb(1'b1, 14'h2502, 32'h0000_00E9);
    @(posedge CLK_SYS);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    wb(1'b0, 14'h2502, 32'h0);
    `CHK("sel1 kept", 32'h0000_00E9, rd)
    wb(1'b0, 14'h2503, 32'h0);
    `CHK("sel2 kept", 32'h0000_0009, rd)
    wb(1'b0, 14'h2704, 32'h0);
    `CHK("spare reset", 32'h0, rd)
    apply(22'h000001, 1'b1, 1'b0);
    wb(1'b0, 14'h2505, 32'h0);
    `CHK("status", 32'h0000_0001, rd)
    $display("reset done");
    wb(1'b1, 14'h2502, 32'h0000_000A);
    base = r1;
    for (int n = 0; n < 5; n++) begin
      apply(22'h000002, 1'b1, 1'b0);
      apply(22'h000000, 1'b0, 1'b0);
    end
    `CHK("edges", 16'h0005, r1 - base)
    $display("edges done");
    // with the enable low the pin must hold its last level
    @(posedge CLK_SYS);
    CLK_EN <= 1'b0;
    apply(22'h000002, 1'b0, 1'b0);
    @(posedge CLK_SYS);
    CLK_EN <= 1'b1;
    apply(22'h000002, 1'b1, 1'b0);
    $display("freeze done");
    stop_test();
  end
endmodule
